// ==== src/pcm_map.svh ====
// Register offsets, reset values and timing figures of the panel-loss and control-mode block.
//Contract
//[RL1] Panel-loss detection runs only when the reset selection is 2 or 3, never with 0 or 1.
//[RL2] Reset selection takes 0 to 3, defaults to 0; 0 and 2 let the reset input act any time, 1 and 3 only during a trip.
//[RL3] A detected panel loss stops the drive in an alarm state and shows the panel-loss alarm code.
//[RL4] No panel-loss alarm while the panel has been absent ever since start-up.
//[RL5] Panel loss is declared only after more than 1 second of unbroken absence.
//[RL6] The absence timer clears whenever the panel is seen again before the threshold.
//[RL7] After a panel-loss stop the outside party reconnects the panel and resets; only a reset ends the alarm.
//[RL8] Flux-vector control only when capacity and pole count both differ from 9999, else V/F control.
//[RL9] Motor capacity takes 9999 or 0.4 kW to 55 kW, the rated size for flux-vector control.
//[RL10] Pole count takes 9999, 2, 4, 6, 12, 14, 16; codes 12/14/16 let the select terminal force V/F.
//[RL11] A control change from the select terminal is applied only while the motor is stopped.
//[RL12] Motor type takes 0, 1, 2 with default 0: standard, constant-torque, standard with 5-point V/F.
//[RL13] Writing the motor type selects the matching thermal characteristic in the same write.
//[RL14] In flux-vector control output starts 0.1 s to 0.2 s after a start command.
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

`define PCM_OFS_RESET_SEL 8'h00
`define PCM_OFS_CAPACITY 8'h04
`define PCM_OFS_POLES 8'h08
`define PCM_OFS_MOTOR_TYPE 8'h0c
`define PCM_OFS_STATUS 8'h10
`define PCM_OFS_IRQ_STATUS 8'h14
`define PCM_OFS_IRQ_MASK 8'h18

`define PCM_RST_RESET_SEL 2'h0
`define PCM_RST_MOTOR_TYPE 2'h0
`define PCM_SETTING_NONE 16'h270f
`define PCM_CAP_MIN 16'h0004
`define PCM_CAP_MAX 16'h0226

`define PCM_BIT_IRQ_LOSS 0
`define PCM_BIT_IRQ_MODE 1
`define PCM_BIT_IRQ_RESET 2
`define PCM_IRQ_W 3

`define PCM_CODE_NONE 8'h00
`define PCM_CODE_PANEL_LOSS 8'h5e
`define PCM_CODE_ALT_PANEL_LOSS 8'h5f

`define PCM_CLK_HZ 25000000
`define PCM_LOSS_TIME_MS 1000
`define PCM_START_DELAY_MS 100
`define PCM_LOSS_CYCLES (`PCM_CLK_HZ / 1000 * `PCM_LOSS_TIME_MS)
`define PCM_START_CYCLES (`PCM_CLK_HZ / 1000 * `PCM_START_DELAY_MS)

`endif

// ==== src/pcm_pkg.sv ====
// Types and setting-decode functions shared by the panel-loss and control-mode block.
package pcm_pkg;
	typedef enum logic [1:0] {
		PCM_IDLE = 2'b00,
		PCM_WAIT = 2'b01,
		PCM_RUN = 2'b10,
		PCM_ALARM = 2'b11
	} pcm_state_e;

	typedef enum logic [1:0] {
		PCM_THERM_STD = 2'b00,
		PCM_THERM_CT = 2'b01
	} pcm_therm_e;

	typedef struct packed {
		logic panel_present;
		logic ctrl_select;
		logic reset_in;
		logic start_cmd;
	} pcm_pins_s;

	function automatic logic pole_valid(input logic [15:0] v);
		case (v)
			16'h270f, 16'h0002, 16'h0004, 16'h0006, 16'h000c, 16'h000e, 16'h0010: pole_valid = 1'b1;
			default: pole_valid = 1'b0;
		endcase
	endfunction : pole_valid

	function automatic logic pole_overridable(input logic [15:0] v);
		pole_overridable = (v == 16'h000c) || (v == 16'h000e) || (v == 16'h0010);
	endfunction : pole_overridable
endpackage : pcm_pkg

// ==== src/pcm_sync.sv ====
// Two-flop synchroniser for a vector of independent pin levels.
`timescale 1ns/1ps
module pcm_sync #(
	parameter int W = 4
) (
	input wire logic clk, // system clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic [W-1:0] d, // asynchronous pin levels
	output logic [W-1:0] q // synchronised levels
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : pcm_sync

// ==== src/pcm_timer.sv ====
// Saturating up-counter that flags when a run has lasted the given number of cycles.
`timescale 1ns/1ps
module pcm_timer #(
	parameter int W = 25,
	parameter int LIMIT = 1000
) (
	input wire logic clk, // system clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic run, // count while high
	input wire logic clear, // restart from zero, wins over run
	output logic done // count has reached the limit
);
	localparam logic [W-1:0] LIM = W'(LIMIT);
	logic [W-1:0] cnt;

	// Refused while the design is built, so a bad limit never reaches a run.
	if (LIMIT < 1 || LIMIT >= (2 ** W))
	begin : g_bad_limit
		$error("pcm_timer: LIMIT does not fit the counter width");
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cnt <= '0;
		else if (clear)
			cnt <= '0;
		else if (run && cnt != LIM)
			cnt <= cnt + W'(1);
	end

	assign done = (cnt == LIM);
endmodule : pcm_timer

// ==== src/pcm_top.sv ====
// Panel-loss supervision, reset gating and V/F versus flux-vector control selection.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "pcm_map.svh"
module pcm_top #(
	parameter int DW = 16,
	parameter int AW = 8,
	parameter int LOSS_CYCLES = `PCM_LOSS_CYCLES,
	parameter int START_CYCLES = `PCM_START_CYCLES
) (
	input wire logic clk, // system clock, 25 MHz
	input wire logic resetn, // asynchronous reset, active low
	input wire logic [AW-1:0] addr, // register byte address
	input wire logic [DW-1:0] wdata, // register write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [DW-1:0] rdata, // read data, valid the cycle after rd
	input wire pcm_pkg::pcm_pins_s pins, // asynchronous terminal levels
	input wire logic alt_panel, // alternate panel kind fitted, same clock
	input wire logic trip_active, // a protective trip elsewhere is active
	output logic output_enable, // drive output running
	output logic alarm_stop, // drive held in panel-loss alarm
	output logic [7:0] display_code, // local display alarm code
	output logic flux_vector, // flux-vector control in effect
	output logic [1:0] thermal_char, // thermal overload characteristic
	output logic drive_reset, // one-cycle accepted reset to the drive
	output logic irq // level interrupt
);
	localparam logic [15:0] NONE = `PCM_SETTING_NONE;

	pcm_pkg::pcm_pins_s pin_s;
	pcm_pkg::pcm_state_e state;
	pcm_pkg::pcm_state_e next_state;
	logic [1:0] reset_sel;
	logic [15:0] capacity;
	logic [15:0] poles;
	logic [1:0] motor_type;
	logic [`PCM_IRQ_W-1:0] irq_status;
	logic [`PCM_IRQ_W-1:0] irq_mask;
	logic [`PCM_IRQ_W-1:0] irq_event;
	logic seen_present;
	logic reset_d;
	logic reset_edge;
	logic reset_ok;
	logic loss_done;
	logic loss_hit;
	logic start_done;
	logic want_flux;
	logic running;
	logic [15:0] wd16;
	logic [DW-1:0] rd_next;

	if (DW < 16 || AW < 5)
	begin : g_bad_width
		$error("pcm_top: DW must be at least 16 and AW at least 5");
	end

	pcm_sync #(
		.W(4)
	) u_sync (
		.clk(clk),
		.resetn(resetn),
		.d(pins),
		.q(pin_s)
	);

	assign wd16 = wdata[15:0];

	// Settings reject out-of-range writes and keep their previous value.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reset_sel <= `PCM_RST_RESET_SEL;
		else if (wr && addr == `PCM_OFS_RESET_SEL && wd16 <= 16'h0003)
			reset_sel <= wd16[1:0]; // RL2
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			capacity <= NONE;
		else if (wr && addr == `PCM_OFS_CAPACITY)
		begin
			if (wd16 == NONE || (wd16 >= `PCM_CAP_MIN && wd16 <= `PCM_CAP_MAX))
				capacity <= wd16; // RL9
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			poles <= NONE;
		else if (wr && addr == `PCM_OFS_POLES && pcm_pkg::pole_valid(wd16))
			poles <= wd16; // RL10
	end

	// Motor type and thermal characteristic share one write so they never disagree.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			motor_type <= `PCM_RST_MOTOR_TYPE;
			thermal_char <= pcm_pkg::PCM_THERM_STD;
		end
		else if (wr && addr == `PCM_OFS_MOTOR_TYPE && wd16 <= 16'h0002)
		begin
			motor_type <= wd16[1:0]; // RL12
			thermal_char <= (wd16[1:0] == 2'h1) ? pcm_pkg::PCM_THERM_CT : pcm_pkg::PCM_THERM_STD; // RL13
		end
	end

	// Only a panel that was once present can be lost.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			seen_present <= 1'b0;
		else if (pin_s.panel_present)
			seen_present <= 1'b1; // RL4
	end

	// The timer counts absence and restarts on any sign of the panel.
	pcm_timer #(
		.W(26),
		.LIMIT(LOSS_CYCLES)
	) u_loss (
		.clk(clk),
		.resetn(resetn),
		.run(reset_sel[1] && seen_present), // RL1
		.clear(pin_s.panel_present || !reset_sel[1]), // RL6
		.done(loss_done)
	);

	// Done marks LOSS_CYCLES absent cycles; one more absent cycle makes it more than the time.
	assign loss_hit = loss_done && !pin_s.panel_present && reset_sel[1] && seen_present; // RL5

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reset_d <= 1'b0;
		else
			reset_d <= pin_s.reset_in;
	end

	assign reset_edge = pin_s.reset_in && !reset_d;
	// The panel-loss alarm itself counts as a protective trip.
	assign reset_ok = reset_edge && (!reset_sel[0] || trip_active || state == pcm_pkg::PCM_ALARM); // RL2

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			drive_reset <= 1'b0;
		else
			drive_reset <= reset_ok;
	end

	assign want_flux = capacity != NONE && poles != NONE
		&& !(pcm_pkg::pole_overridable(poles) && pin_s.ctrl_select); // RL8 RL10

	assign running = (state == pcm_pkg::PCM_RUN) || (state == pcm_pkg::PCM_WAIT);

	// The mode is frozen while the motor turns, so a terminal change waits for the stop.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			flux_vector <= 1'b0;
		else if (!running)
			flux_vector <= want_flux; // RL11
	end

	pcm_timer #(
		.W(24),
		.LIMIT(START_CYCLES)
	) u_start (
		.clk(clk),
		.resetn(resetn),
		.run(state == pcm_pkg::PCM_WAIT),
		.clear(state != pcm_pkg::PCM_WAIT),
		.done(start_done)
	);

	always_comb
	begin
		next_state = state;
		case (state)
			pcm_pkg::PCM_IDLE:
			begin
				if (loss_hit)
					next_state = pcm_pkg::PCM_ALARM;
				else if (pin_s.start_cmd)
					next_state = flux_vector ? pcm_pkg::PCM_WAIT : pcm_pkg::PCM_RUN; // RL14
			end
			pcm_pkg::PCM_WAIT:
			begin
				if (loss_hit)
					next_state = pcm_pkg::PCM_ALARM;
				else if (!pin_s.start_cmd)
					next_state = pcm_pkg::PCM_IDLE;
				else if (start_done)
					next_state = pcm_pkg::PCM_RUN; // RL14
			end
			pcm_pkg::PCM_RUN:
			begin
				if (loss_hit)
					next_state = pcm_pkg::PCM_ALARM; // RL3
				else if (!pin_s.start_cmd)
					next_state = pcm_pkg::PCM_IDLE;
			end
			pcm_pkg::PCM_ALARM:
			begin
				if (reset_ok)
					next_state = pcm_pkg::PCM_IDLE; // RL7
			end
			default: next_state = pcm_pkg::PCM_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			state <= pcm_pkg::PCM_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			output_enable <= 1'b0;
			alarm_stop <= 1'b0;
			display_code <= `PCM_CODE_NONE;
		end
		else
		begin
			output_enable <= (next_state == pcm_pkg::PCM_RUN);
			alarm_stop <= (next_state == pcm_pkg::PCM_ALARM); // RL3
			if (next_state == pcm_pkg::PCM_ALARM)
				display_code <= alt_panel ? `PCM_CODE_ALT_PANEL_LOSS : `PCM_CODE_PANEL_LOSS; // RL3
			else
				display_code <= `PCM_CODE_NONE;
		end
	end

	assign irq_event[`PCM_BIT_IRQ_LOSS] = (state != pcm_pkg::PCM_ALARM)
		&& (next_state == pcm_pkg::PCM_ALARM);
	assign irq_event[`PCM_BIT_IRQ_MODE] = !running && (flux_vector != want_flux);
	assign irq_event[`PCM_BIT_IRQ_RESET] = reset_ok;

	// A new event in the clearing cycle survives the write-one-to-clear.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			irq_status <= '0;
		else if (wr && addr == `PCM_OFS_IRQ_STATUS)
			irq_status <= (irq_status & ~wdata[`PCM_IRQ_W-1:0]) | irq_event;
		else
			irq_status <= irq_status | irq_event;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			irq_mask <= '0;
		else if (wr && addr == `PCM_OFS_IRQ_MASK)
			irq_mask <= wdata[`PCM_IRQ_W-1:0];
	end

	assign irq = |(irq_status & irq_mask);

	always_comb
	begin
		rd_next = '0;
		case (addr)
			`PCM_OFS_RESET_SEL: rd_next[1:0] = reset_sel;
			`PCM_OFS_CAPACITY: rd_next[15:0] = capacity;
			`PCM_OFS_POLES: rd_next[15:0] = poles;
			`PCM_OFS_MOTOR_TYPE: rd_next[1:0] = motor_type;
			`PCM_OFS_STATUS: rd_next[6:0] = {trip_active, thermal_char, seen_present,
				output_enable, alarm_stop, flux_vector};
			`PCM_OFS_IRQ_STATUS: rd_next[`PCM_IRQ_W-1:0] = irq_status;
			`PCM_OFS_IRQ_MASK: rd_next[`PCM_IRQ_W-1:0] = irq_mask;
			default: rd_next = '0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rdata <= '0;
		else if (rd)
			rdata <= rd_next;
		else
			rdata <= '0;
	end
endmodule : pcm_top

// ==== dv/pcm_panel_model.sv ====
// Behavioural model of the detachable operator panel seen at the presence pin.
`timescale 1ns/1ps
module pcm_panel_model (
	input wire logic clk, // clock
	input wire logic plug, // panel fitted
	output logic present = 1'b0 // presence level
);
	always_ff @(posedge clk)
	begin
		present <= plug;
	end
endmodule : pcm_panel_model

// ==== dv/pcm_top_assertions.sv ====
// Port assertions for the panel-loss and control-mode block.
`timescale 1ns/1ps
module pcm_top_assertions #(
	parameter int LOSS_CYCLES = 20,
	parameter int START_CYCLES = 10
) (
	input wire logic clk, // clock
	input wire logic resetn, // reset
	input wire logic [7:0] addr, // address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire pcm_pkg::pcm_pins_s pins, // pins
	input wire logic alt_panel, // alt panel
	input wire logic output_enable, // running
	input wire logic alarm_stop, // alarm
	input wire logic [7:0] display_code, // code
	input wire logic flux_vector, // flux mode
	input wire logic [1:0] thermal_char, // thermal
	input wire logic drive_reset // reset pulse
);
	int gone;
	int run;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// Raw pin run lengths; the synchroniser adds two cycles on top of these.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gone <= 0;
			run <= 0;
		end
		else
		begin
			gone <= pins.panel_present ? 0 : gone + 1;
			run <= pins.start_cmd ? run + 1 : 0;
		end
	end
	a_alarm_code:
	assert property ($rose(alarm_stop) |-> !output_enable &&
		display_code == (alt_panel ? 8'h5f : 8'h5e)) else $error("bad alarm entry");
	a_loss_time:
	assert property ($rose(alarm_stop) |-> gone >= LOSS_CYCLES + 2) else $error("early loss");
	a_alarm_exit:
	assert property ($fell(alarm_stop) |-> drive_reset) else $error("alarm left alone");
	a_reset_pulse:
	assert property (drive_reset |=> !drive_reset) else $error("long reset pulse");
	a_mode_stopped:
	assert property ($changed(flux_vector) |-> !$past(output_enable)) else $error("mode moved");
	a_therm_write:
	assert property (wr && addr == 8'h0c && wdata < 16'h3 |=>
		thermal_char == ($past(wdata) == 16'h1 ? 2'h1 : 2'h0)) else $error("bad thermal");
	a_flux_delay:
	assert property ($rose(output_enable) && flux_vector |-> run > START_CYCLES)
		else $error("flux start early");
	a_vf_prompt:
	assert property (run == 6 && !flux_vector && !alarm_stop |-> output_enable)
		else $error("slow start");
endmodule : pcm_top_assertions
bind pcm_top pcm_top_assertions #(.LOSS_CYCLES(LOSS_CYCLES), .START_CYCLES(START_CYCLES)) i_chk (
	.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .pins(pins),
	.alt_panel(alt_panel), .output_enable(output_enable), .alarm_stop(alarm_stop),
	.display_code(display_code), .flux_vector(flux_vector), .thermal_char(thermal_char),
	.drive_reset(drive_reset)
);

// ==== dv/pcm_tb_top.sv ====
// Self-checking bench for the panel-loss and control-mode block.
`timescale 1ns/1ps
module pcm_tb_top;
	localparam int LC = 20;
	localparam int SC = 10;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cs = 1'b0;
	logic rst_in = 1'b0;
	logic start = 1'b0;
	logic plug = 1'b0;
	logic alt = 1'b0;
	logic trip = 1'b0;
	logic present;
	logic [15:0] rdata;
	logic oe, alarm, fv, dres, irq;
	logic [7:0] code;
	logic [1:0] therm;
	int num_errors = 0;
	int checks = 0;
	int seed = 13060;
	int resets = 0;
	pcm_pkg::pcm_pins_s pins;
	assign pins = {present, cs, rst_in, start};
	always #20 clk = ~clk;
	pcm_panel_model i_pcm_panel_model (.clk(clk), .plug(plug), .present(present));
	pcm_top #(.LOSS_CYCLES(LC), .START_CYCLES(SC)) i_pcm_top (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pins(pins), .alt_panel(alt), .trip_active(trip),
		.output_enable(oe), .alarm_stop(alarm), .display_code(code), .flux_vector(fv),
		.thermal_char(therm), .drive_reset(dres), .irq(irq)
	);
	task automatic chkw(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chkw
	task automatic chkb(input string n, input logic e, input logic g);
		chkw(n, {15'h0, e}, {15'h0, g});
	endtask : chkb
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chkw("register", e, rdata & m);
	endtask : rchk
	// Counts the drive reset pulses seen while the reset pin is pulsed.
	task automatic pulse_reset(output int seen);
		seen = 0;
		rst_in <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			if (k == 4)
				rst_in <= 1'b0;
			tick(1);
			seen += int'(dres);
		end
	endtask : pulse_reset
	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	initial
	begin
		#400000;
		num_errors++;
		summarize();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		wreg(8'h1c, 16'h0003);
		rchk(8'h00, 16'hffff, 16'h0000);
		wreg(8'h04, 16'h0227 + 16'($unsigned($random(seed)) % 64));
		wreg(8'h08, 16'h0005);
		wreg(8'h0c, 16'h0003);
		rchk(8'h04, 16'hffff, 16'h270f);
		rchk(8'h08, 16'hffff, 16'h270f);
		rchk(8'h0c, 16'hffff, 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			wreg(8'h0c, 16'(i));
			rchk(8'h10, 16'h0030, (i == 1) ? 16'h0010 : 16'h0000);
			chkw("thermal", 16'(i == 1), {14'h0, therm});
		end
		for (int i = 0; i < 6; i++)
		begin
			cs <= i[0];
			wreg(8'h04, 16'h0004 + 16'($unsigned($random(seed)) % 547));
			wreg(8'h08, (i < 3) ? 16'(2 * i + 2) : 16'(2 * i + 6));
			tick(4);
			chkb("flux", !(i > 2 && i[0]), fv);
		end
		cs <= 1'b0;
		wreg(8'h08, 16'h270f);
		tick(4);
		chkb("flux", 1'b0, fv);
		wreg(8'h08, 16'h000e);
		tick(4);
		chkb("flux", 1'b1, fv);
		start <= 1'b1;
		tick(SC);
		chkb("run", 1'b0, oe);
		tick(8);
		chkb("run", 1'b1, oe);
		cs <= 1'b1;
		tick(4);
		chkb("flux", 1'b1, fv);
		wreg(8'h14, 16'h0002);
		start <= 1'b0;
		tick(6);
		chkb("flux", 1'b0, fv);
		rchk(8'h14, 16'h0002, 16'h0002);
		start <= 1'b1;
		tick(4);
		chkb("run", 1'b1, oe);
		start <= 1'b0;
		cs <= 1'b0;
		// The fifth pass is selection 1 with a trip active, one of the two cases (the other is the panel-loss alarm) in which it accepts a reset.
		for (int s = 0; s < 5; s++)
		begin
			trip <= (s == 4);
			wreg(8'h00, (s == 4) ? 16'h0001 : 16'(s));
			pulse_reset(resets);
			chkw("drive_reset", 16'(s != 1 && s != 3), 16'(resets));
			rchk(8'h14, 16'h0004, (s == 1 || s == 3) ? 16'h0 : 16'h4);
			wreg(8'h14, 16'h0007);
		end
		trip <= 1'b0;
		wreg(8'h00, 16'h0002);
		tick(LC + 8);
		chkb("alarm", 1'b0, alarm);
		for (int s = 0; s < 4; s++)
		begin
			alt <= s[0];
			plug <= 1'b1;
			wreg(8'h00, 16'(s));
			tick(4);
			plug <= 1'b0;
			tick(LC - 4);
			plug <= 1'b1;
			tick(4);
			plug <= 1'b0;
			tick(LC);
			chkb("alarm", 1'b0, alarm);
			tick(8);
			chkb("alarm", s > 1, alarm);
			chkw("code", (s < 2) ? 16'h0 : (s[0] ? 16'h5f : 16'h5e), {8'h0, code});
			wreg(8'h18, 16'(s != 3));
			tick(1);
			chkb("irq", s == 2, irq);
			rchk(8'h14, 16'h0001, 16'(s > 1));
			plug <= 1'b1;
			wreg(8'h14, 16'h0001);
			tick(4);
			chkb("alarm", s > 1, alarm);
			pulse_reset(resets);
			chkw("drive_reset", 16'(s != 1), 16'(resets));
			chkb("alarm", 1'b0, alarm);
			chkb("irq", 1'b0, irq);
		end
		summarize();
	end
endmodule : pcm_tb_top
